/* src/scl_status_regs.v */
`timescale 1ns/1ps
`include "scl_status_map.vh"
// Summary of operation
// - with interrupt enabled, checksum mismatch holds ready pin low until cleared
// - writing lock key equal to 0xa5 clears the checksum interrupt
// - checksum always computed and readable even with interrupt disabled
// - interrupt disabled: mismatch leaves ready pin untouched
// - bits 11 down to 4 read as zero
// - four ready flags in bits 3..0, reset 1, go 0 on new result
// - status register read returns all ready flags to 1, except those getting a new result in the same cycle
// - reading a channel result does not touch its ready flag
module scl_status_regs (
    // clock and reset
    input  wire        CLK,
    input  wire        RST,
    // register port
    input  wire        WR_EN,
    input  wire [23:0] WR_DATA,
    input  wire        RD_EN,
    output reg  [23:0] RD_DATA,
    input  wire        RESULT_RD,
    input  wire        LOCK_WR,
    input  wire [7:0]  LOCK_DATA,
    // checksum
    input  wire [15:0] CFG_CHECKSUM,
    input  wire        CHECK_DONE,
    input  wire        CHECK_MISMATCH,
    output reg  [15:0] CONFIG_MAP_CHECKSUM,
    // conversion side
    input  wire [3:0]  NEW_RESULT,
    input  wire [23:0] SAMPLE,
    output reg  [31:0] SAMPLE_WORD,
    output reg  [5:0]  SAMPLE_BITS,
    // link crc
    input  wire        SEQ_END,
    input  wire [15:0] LINK_CRC,
    output reg  [31:0] CRC_TRAILER,
    output reg  [5:0]  CRC_BITS,
    // pins
    output reg         READY_PIN_N
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    reg         crc_width_ff;
    reg  [1:0]  fmt_ff;
    reg         link_crc_en_ff;
    reg         int_en_ff;
    reg         int_ff;
    reg  [3:0]  channel_ready_flags_ff;
    reg         nxt_crc_width;
    reg  [1:0]  nxt_fmt;
    reg         nxt_link_crc_en;
    reg         nxt_int_en;
    reg         nxt_int;
    reg  [3:0]  nxt_flags;
    reg  [23:0] nxt_rd_data;
    reg  [15:0] nxt_checksum;
    reg  [31:0] nxt_trailer;
    reg  [5:0]  nxt_crc_bits;
    wire [31:0] fmt_word;
    wire [5:0]  fmt_bits;

    function [23:0] status_word;
        input        cw;
        input [1:0]  fm;
        input        le;
        input        ie;
        input [3:0]  fl;
        begin
            status_word = {5'h00, cw, fm, le, ie, 2'b00, 8'h00, fl};
        end
    endfunction

    scl_word_format u_fmt (
        .fmt       (fmt_ff),
        .sample    (SAMPLE),
        .word      (fmt_word),
        .word_bits (fmt_bits)
    );

    // ---------------------------------------------------------------
    // configuration fields
    // ---------------------------------------------------------------
    // reserved 13:12 are not stored; host keeps them zero
    always @* begin
        nxt_crc_width   = crc_width_ff;
        nxt_fmt         = fmt_ff;
        nxt_link_crc_en = link_crc_en_ff;
        nxt_int_en      = int_en_ff;
        if (WR_EN) begin
            nxt_crc_width   = WR_DATA[`SCL_BIT_CRC_WIDTH];
            nxt_fmt         = WR_DATA[`SCL_BIT_FMT_HI:`SCL_BIT_FMT_LO];
            nxt_link_crc_en = WR_DATA[`SCL_BIT_LINK_CRC_EN];
            nxt_int_en      = WR_DATA[`SCL_BIT_INT_EN];
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            crc_width_ff   <= `SCL_RST_CRC_WIDTH;
            fmt_ff         <= `SCL_RST_FMT;
            link_crc_en_ff <= `SCL_RST_LINK_CRC_EN;
            int_en_ff      <= `SCL_RST_INT_EN;
        end else begin
            crc_width_ff   <= nxt_crc_width;
            fmt_ff         <= nxt_fmt;
            link_crc_en_ff <= nxt_link_crc_en;
            int_en_ff      <= nxt_int_en;
        end
    end

    // ---------------------------------------------------------------
    // checksum interrupt and ready pin
    // ---------------------------------------------------------------
    always @* begin
        nxt_int = int_ff;
        if (LOCK_WR && LOCK_DATA == `SCL_UNLOCK_KEY) begin
            nxt_int = 1'b0;
        end
        // new mismatch wins over a same-cycle clear
        if (int_en_ff && CHECK_DONE && CHECK_MISMATCH) begin
            nxt_int = 1'b1;
        end
    end

    // pin follows interrupt; data-ready pulses are outside this slice
    always @(posedge CLK) begin
        if (RST) begin
            int_ff      <= 1'b0;
            READY_PIN_N <= 1'b1;
        end else begin
            int_ff      <= nxt_int;
            READY_PIN_N <= ~nxt_int;
        end
    end

    // ---------------------------------------------------------------
    // ready flags and status read
    // ---------------------------------------------------------------
    always @* begin
        nxt_flags   = channel_ready_flags_ff;
        nxt_rd_data = RD_DATA;
        if (RD_EN) begin
            // result reads have no path here; only this read restores
            nxt_flags   = `SCL_RST_READY;
            nxt_rd_data = status_word(crc_width_ff, fmt_ff, link_crc_en_ff,
                                      int_en_ff, channel_ready_flags_ff);
        end
        // a result landing with the read is kept for the next read
        nxt_flags = nxt_flags & ~NEW_RESULT;
    end

    always @(posedge CLK) begin
        if (RST) begin
            channel_ready_flags_ff <= `SCL_RST_READY;
            RD_DATA                <= 24'h000000;
        end else begin
            channel_ready_flags_ff <= nxt_flags;
            RD_DATA                <= nxt_rd_data;
        end
    end

    // ---------------------------------------------------------------
    // configuration checksum capture
    // ---------------------------------------------------------------
    always @* begin
        nxt_checksum = CONFIG_MAP_CHECKSUM;
        if (CHECK_DONE) begin
            nxt_checksum = CFG_CHECKSUM;
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            CONFIG_MAP_CHECKSUM <= 16'h0000;
        end else begin
            CONFIG_MAP_CHECKSUM <= nxt_checksum;
        end
    end

    // ---------------------------------------------------------------
    // sample word
    // ---------------------------------------------------------------
    always @(posedge CLK) begin
        if (RST) begin
            SAMPLE_WORD <= 32'h00000000;
            SAMPLE_BITS <= 6'h00;
        end else begin
            SAMPLE_WORD <= fmt_word;
            SAMPLE_BITS <= fmt_bits;
        end
    end

    // ---------------------------------------------------------------
    // link crc trailer
    // ---------------------------------------------------------------
    always @* begin
        nxt_trailer  = CRC_TRAILER;
        nxt_crc_bits = CRC_BITS;
        if (SEQ_END) begin
            if (!link_crc_en_ff) begin
                nxt_trailer  = 32'h00000000;
                nxt_crc_bits = 6'h00;
            end else if (crc_width_ff) begin
                // zero tail keeps the trailer one whole 32-bit word
                nxt_trailer  = {LINK_CRC, 16'h0000};
                nxt_crc_bits = 6'h20;
            end else begin
                nxt_trailer  = {16'h0000, LINK_CRC};
                nxt_crc_bits = 6'h10;
            end
        end
    end

    always @(posedge CLK) begin
        if (RST) begin
            CRC_TRAILER <= 32'h00000000;
            CRC_BITS    <= 6'h00;
        end else begin
            CRC_TRAILER <= nxt_trailer;
            CRC_BITS    <= nxt_crc_bits;
        end
    end
endmodule

/* src/scl_status_map.vh */
`ifndef SCL_STATUS_MAP_VH
`define SCL_STATUS_MAP_VH
// ---------------------------------------------------------------
// status and link control field layout
// ---------------------------------------------------------------
`define SCL_BIT_CRC_WIDTH      18
`define SCL_BIT_FMT_HI         17
`define SCL_BIT_FMT_LO         16
`define SCL_BIT_LINK_CRC_EN    15
`define SCL_BIT_INT_EN         14
`define SCL_RST_CRC_WIDTH      1'b0
`define SCL_RST_FMT            2'b01
`define SCL_RST_LINK_CRC_EN    1'b0
`define SCL_RST_INT_EN         1'b0
`define SCL_RST_READY          4'hf
// ---------------------------------------------------------------
// sample format codes and unlock key
// ---------------------------------------------------------------
`define SCL_FMT_16R            2'b00
`define SCL_FMT_24             2'b01
`define SCL_FMT_32Z            2'b10
`define SCL_FMT_32S            2'b11
`define SCL_UNLOCK_KEY         8'ha5
`endif

/* src/scl_word_format.v */
`timescale 1ns/1ps
`include "scl_status_map.vh"
module scl_word_format (
    // control
    input  wire [1:0]  fmt,
    // data
    input  wire [23:0] sample,
    output reg  [31:0] word,
    output reg  [5:0]  word_bits
);
    reg [16:0] rnd;
    always @* begin
        rnd = {sample[23], sample[23:8]} + {16'h0000, sample[7]};
        // saturate so rounding never wraps to the opposite sign
        if (rnd[16] != rnd[15]) begin
            rnd[15:0] = sample[23] ? 16'h8000 : 16'h7fff;
        end
        case (fmt)
            `SCL_FMT_16R: begin
                word      = {16'h0000, rnd[15:0]};
                word_bits = 6'h10;
            end
            `SCL_FMT_24: begin
                word      = {8'h00, sample};
                word_bits = 6'h18;
            end
            `SCL_FMT_32Z: begin
                word      = {sample, 8'h00};
                word_bits = 6'h20;
            end
            default: begin
                word      = {{8{sample[23]}}, sample};
                word_bits = 6'h20;
            end
        endcase
    end
endmodule

/* verification/scl_host.sv */
`timescale 1ns/1ps
module scl_host (
    input  wire        CLK,
    output reg         WR_EN,
    output reg  [23:0] WR_DATA,
    output reg         RD_EN,
    output reg         LOCK_WR,
    output reg  [7:0]  LOCK_DATA
);
    initial {WR_EN, WR_DATA, RD_EN, LOCK_WR, LOCK_DATA} = 35'h0;
    // released data lines invert so stale values cannot pass
    task wr(input [23:0] d);
        begin
            @(posedge CLK) WR_EN <= 1'b1;
            WR_DATA <= d & 24'hffcfff;
            @(posedge CLK) WR_EN <= 1'b0;
            WR_DATA <= ~WR_DATA;
        end
    endtask
    task rd(input integer n);
        begin
            @(posedge CLK) RD_EN <= 1'b1;
            repeat (n) @(posedge CLK);
            RD_EN <= 1'b0;
        end
    endtask
    task lock(input [7:0] k);
        begin
            @(posedge CLK) LOCK_WR <= 1'b1;
            LOCK_DATA <= k;
            @(posedge CLK) LOCK_WR <= 1'b0;
            LOCK_DATA <= ~k;
        end
    endtask
endmodule

/* verification/scl_chk_sva.sv */
`timescale 1ns/1ps
`include "scl_status_map.vh"
module scl_chk (
    input wire        CLK,
    input wire        RST,
    input wire        WR_EN,
    input wire [23:0] WR_DATA,
    input wire        RD_EN,
    input wire        LOCK_WR,
    input wire [7:0]  LOCK_DATA,
    input wire [3:0]  NEW_RESULT,
    input wire        CHECK_DONE,
    input wire        CHECK_MISMATCH,
    input wire [15:0] CFG_CHECKSUM,
    input wire [23:0] RD_DATA,
    input wire [15:0] CONFIG_MAP_CHECKSUM,
    input wire        READY_PIN_N
);
    reg  ie_ff;
    wire err = CHECK_DONE && CHECK_MISMATCH;
    wire key = LOCK_WR && LOCK_DATA == `SCL_UNLOCK_KEY;
    // mirror of the interrupt enable, the pin rules hinge on it
    always @(posedge CLK) ie_ff <= RST ? 1'b0 : (WR_EN ? WR_DATA[`SCL_BIT_INT_EN] : ie_ff);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    AST_PIN_SET: assert property (err && ie_ff |=> !READY_PIN_N)
        else $error("pin not low after checksum error");
    AST_PIN_HOLD: assert property (!READY_PIN_N && !key |=> !READY_PIN_N)
        else $error("pin released without key");
    AST_PIN_CLEAR: assert property (key && !err |=> READY_PIN_N)
        else $error("key did not release pin");
    AST_PIN_QUIET: assert property (READY_PIN_N && !(err && ie_ff) |=> READY_PIN_N)
        else $error("pin fell without enabled error");
    AST_SUM: assert property (CHECK_DONE |=> CONFIG_MAP_CHECKSUM == $past(CFG_CHECKSUM))
        else $error("checksum not captured");
    AST_RSVD: assert property (RD_DATA[13:4] == 10'h000)
        else $error("unused bits not zero");
    AST_RD_RESTORE: assert property (RD_EN && NEW_RESULT == 4'h0 ##1
        RD_EN && NEW_RESULT == 4'h0 |=> RD_DATA[3:0] == 4'hf)
        else $error("flags not restored by read");
    AST_NEW_WINS: assert property ($past(NEW_RESULT[0]) && RD_EN |=> !RD_DATA[0])
        else $error("new result lost");
endmodule
bind scl_status_regs scl_chk chk_u (.CLK(CLK), .RST(RST), .WR_EN(WR_EN), .WR_DATA(WR_DATA),
    .RD_EN(RD_EN), .LOCK_WR(LOCK_WR), .LOCK_DATA(LOCK_DATA), .NEW_RESULT(NEW_RESULT),
    .CHECK_DONE(CHECK_DONE), .CHECK_MISMATCH(CHECK_MISMATCH), .CFG_CHECKSUM(CFG_CHECKSUM),
    .RD_DATA(RD_DATA), .CONFIG_MAP_CHECKSUM(CONFIG_MAP_CHECKSUM), .READY_PIN_N(READY_PIN_N));

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    reg         CLK, RST, RESULT_RD, CHECK_DONE, CHECK_MISMATCH, SEQ_END;
    reg  [15:0] CFG_CHECKSUM, LINK_CRC;
    reg  [3:0]  NEW_RESULT;
    reg  [23:0] SAMPLE;
    wire        WR_EN, RD_EN, LOCK_WR, READY_PIN_N;
    wire [23:0] WR_DATA, RD_DATA;
    wire [7:0]  LOCK_DATA;
    wire [15:0] CONFIG_MAP_CHECKSUM;
    wire [31:0] SAMPLE_WORD, CRC_TRAILER;
    wire [5:0]  SAMPLE_BITS, CRC_BITS;
    integer     n_errors = 0, check_count = 0, cyc = 0, i;
    reg  [63:0] rows [0:3] = '{{2'b00, 24'hc3a580, 32'h0000c3a6, 6'd16},
        {2'b01, 24'hc3a580, 32'h00c3a580, 6'd24}, {2'b10, 24'hc3a580, 32'hc3a58000, 6'd32},
        {2'b11, 24'hc3a580, 32'hffc3a580, 6'd32}};
    scl_host host_u (.CLK(CLK), .WR_EN(WR_EN), .WR_DATA(WR_DATA), .RD_EN(RD_EN),
        .LOCK_WR(LOCK_WR), .LOCK_DATA(LOCK_DATA));
    scl_status_regs dut_u (.CLK(CLK), .RST(RST), .WR_EN(WR_EN), .WR_DATA(WR_DATA),
        .RD_EN(RD_EN), .RD_DATA(RD_DATA), .RESULT_RD(RESULT_RD), .LOCK_WR(LOCK_WR),
        .LOCK_DATA(LOCK_DATA), .CFG_CHECKSUM(CFG_CHECKSUM), .CHECK_DONE(CHECK_DONE),
        .CHECK_MISMATCH(CHECK_MISMATCH), .CONFIG_MAP_CHECKSUM(CONFIG_MAP_CHECKSUM),
        .NEW_RESULT(NEW_RESULT), .SAMPLE(SAMPLE), .SAMPLE_WORD(SAMPLE_WORD),
        .SAMPLE_BITS(SAMPLE_BITS), .SEQ_END(SEQ_END), .LINK_CRC(LINK_CRC),
        .CRC_TRAILER(CRC_TRAILER), .CRC_BITS(CRC_BITS), .READY_PIN_N(READY_PIN_N));
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("[ERR] %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", check_count, n_errors);
            if (n_errors == 0 && check_count > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    task chkev(input m, input [15:0] s);
        begin
            @(posedge CLK) {CHECK_DONE, CHECK_MISMATCH, CFG_CHECKSUM} <= {1'b1, m, s};
            @(posedge CLK) CHECK_DONE <= 1'b0;
            #1;
        end
    endtask
    task seq(input [23:0] c, input [15:0] k, input [31:0] e, input [5:0] b);
        begin
            host_u.wr(c);
            @(posedge CLK) {SEQ_END, LINK_CRC} <= {1'b1, k};
            @(posedge CLK) SEQ_END <= 1'b0;
            #1 chk("trailer", e, CRC_TRAILER);
            chk("crc_bits", 32'(b), 32'(CRC_BITS));
            $display("link crc case done");
        end
    endtask
    // run is well under 400 cycles; the ceiling only catches a hang
    always @(posedge CLK) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            n_errors = n_errors + 1;
            give_verdict;
        end
    end
    initial begin
        RST            <= 1'b1;
        RESULT_RD      <= 1'b0;
        CHECK_DONE     <= 1'b0;
        CHECK_MISMATCH <= 1'b0;
        SEQ_END        <= 1'b0;
        CFG_CHECKSUM   <= 16'h0000;
        LINK_CRC       <= 16'h0000;
        NEW_RESULT     <= 4'h0;
        SAMPLE         <= 24'h000000;
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        for (i = 0; i < 4; i = i + 1) begin
            host_u.wr({6'h00, rows[i][63:62], 16'h0000});
            SAMPLE <= rows[i][61:38];
            @(posedge CLK) #1 chk("word", rows[i][37:6], SAMPLE_WORD);
            chk("word_bits", 32'(rows[i][5:0]), 32'(SAMPLE_BITS));
            $display("format row %0d done", i);
        end
        host_u.wr(24'h010000);
        host_u.rd(1);
        #1 chk("status", 32'h01000f, 32'(RD_DATA));
        fork
            host_u.rd(2);
            begin
                @(posedge CLK) NEW_RESULT <= 4'h5;
                @(posedge CLK) NEW_RESULT <= 4'h0;
            end
        join
        #1 chk("flags", 32'ha, 32'(RD_DATA[3:0]));
        @(posedge CLK) NEW_RESULT <= 4'h5;
        @(posedge CLK) {NEW_RESULT, RESULT_RD} <= {4'h0, 1'b1};
        @(posedge CLK) RESULT_RD <= 1'b0;
        host_u.rd(1);
        #1 chk("flags", 32'ha, 32'(RD_DATA[3:0]));
        host_u.rd(2);
        #1 chk("flags", 32'hf, 32'(RD_DATA[3:0]));
        $display("ready flag test done");
        chkev(1'b1, 16'h1234);
        chk("pin", 32'h1, 32'(READY_PIN_N));
        chk("checksum", 32'h1234, 32'(CONFIG_MAP_CHECKSUM));
        host_u.wr(24'h014000);
        chkev(1'b1, 16'hbeef);
        chk("pin", 32'h0, 32'(READY_PIN_N));
        chk("checksum", 32'hbeef, 32'(CONFIG_MAP_CHECKSUM));
        host_u.lock(8'h5a);
        #1 chk("pin", 32'h0, 32'(READY_PIN_N));
        fork
            chkev(1'b1, 16'h0f0f);
            host_u.lock(8'ha5);
        join
        chk("pin", 32'h0, 32'(READY_PIN_N));
        host_u.lock(8'ha5);
        #1 chk("pin", 32'h1, 32'(READY_PIN_N));
        $display("interrupt test done");
        seq(24'h058000, 16'hbeef, 32'hbeef0000, 6'd32);
        seq(24'h018000, 16'h1d0f, 32'h00001d0f, 6'd16);
        seq(24'h010000, 16'h55aa, 32'h00000000, 6'd0);
        host_u.wr(24'h014000);
        chkev(1'b1, 16'h3c3c);
        chk("pin", 32'h0, 32'(READY_PIN_N));
        @(posedge CLK) RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        #1 chk("pin", 32'h1, 32'(READY_PIN_N));
        chk("checksum", 32'h0, 32'(CONFIG_MAP_CHECKSUM));
        host_u.rd(1);
        #1 chk("status", 32'h01000f, 32'(RD_DATA));
        $display("mid-run reset test done");
        give_verdict;
    end
endmodule
